// ==== adcc_control.sv ====
// Converter control register with parallel and serial write paths
//
// Summary of operation
// - Six bits: address, convert, standby, coding
// - Register loads over parallel or serial
// - Power-on reset clears all bits
// - Short frame leaves register unchanged
// - Short frame with convert set reconverts
// - Channel number is address plus one
// - Bit2 most, bit0 least significant
// - Address write times pulse; conversion follows only with convert bit set
// - Standby bit drives power-down output
// - Coding bit selects result format
// - One means twos complement, zero binary
// - First six falling edges captured, rest ignored
// - Convert bit one launches pulse, then converts
// - Parallel write latches data lines
`timescale 1ns/1ns
`include "adcc_cfg.svh"
module adcc_control
  import adcc_pkg::*;
#(
  parameter int ACQ_CYCLES = `ADCC_ACQ_CYCLES,
  parameter int RES_W      = `ADCC_RESULT_W
) (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire logic                   serial_mode,
  input  wire logic                   wr_n,
  input  wire logic                   cs_n,
  input  wire logic [`ADCC_CTRL_W-1:0] data_line,
  input  wire logic                   sclk,
  input  wire logic                   write_frame_sync_n,
  input  wire logic                   serial_data_in,
  input  wire logic                   hw_convert_start_n,
  input  wire logic [RES_W-1:0]       raw_result,
  input  wire logic                   raw_result_valid,
  output logic [2:0]                  chan_select,
  output logic [3:0]                  chan_number,
  output logic                        standby,
  output logic                        twos_comp_sel,
  output logic                        acq_pulse,
  output logic                        convert_start,
  output logic [RES_W-1:0]            result_out,
  output logic                        result_valid
);
  initial begin
    if (RES_W < 2) $error("adcc_control: RES_W too small");
  end

  // ==========================================================
  // Pin synchronisers
  logic [1:0] mode_sync;
  logic [1:0] wr_sync;
  logic [1:0] cs_sync;
  logic [1:0] hw_sync;
  logic [1:0] frame_sync;
  logic [1:0] full_sync;
  logic [`ADCC_CTRL_W-1:0] data_s1;
  logic [`ADCC_CTRL_W-1:0] data_s2;
  logic [`ADCC_SER_BITS-1:0] ser_word;
  logic                      ser_full;
  logic       wr_prev;
  logic       hw_prev;
  logic       full_prev;
  logic [1:0] frame_dly;

  always_ff @(posedge mclk) begin
    mode_sync  <= {mode_sync[0], serial_mode};
    wr_sync    <= {wr_sync[0], wr_n};
    cs_sync    <= {cs_sync[0], cs_n};
    hw_sync    <= {hw_sync[0], hw_convert_start_n};
    frame_sync <= {frame_sync[0], write_frame_sync_n};
    full_sync  <= {full_sync[0], ser_full};
    data_s1    <= data_line;
    data_s2    <= data_s1;
  end

  // Edge history reads only second stages
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_prev   <= 1'b1;
      hw_prev   <= 1'b1;
      full_prev <= 1'b0;
      frame_dly <= 2'b11;
    end else begin
      wr_prev   <= wr_sync[1];
      hw_prev   <= hw_sync[1];
      full_prev <= full_sync[1];
      frame_dly <= {frame_dly[0], frame_sync[1]};
    end
  end

  // ==========================================================
  // Serial receiver on the link clock

  adcc_serial_rx #(
    .BITS (`ADCC_SER_BITS)
  ) u_rx (
    .sclk               (sclk),
    .write_frame_sync_n (write_frame_sync_n),
    .serial_data_in     (serial_data_in),
    .word               (ser_word),
    .word_full          (ser_full)
  );

  // ==========================================================
  // Write decode
  logic ser_write;
  logic frame_fall;
  logic frame_rise;
  logic hw_rise;

  // Frame end seen one cycle late so a full word crossing lands first
  assign frame_fall = frame_dly[1] && !frame_dly[0];
  assign frame_rise = !frame_dly[1] && frame_dly[0];
  assign hw_rise    = !hw_prev && hw_sync[1];

  logic par_take;
  assign par_take  = mode_sync[1] && !wr_prev && wr_sync[1]
                   && !cs_sync[1];
  assign ser_write = !mode_sync[1] && full_sync[1] && !full_prev;

  // ==========================================================
  // Control register
  logic [`ADCC_CTRL_W-1:0] ctrl;
  logic [`ADCC_CTRL_W-1:0] next_ctrl;
  logic                    word_seen;
  logic                    next_word_seen;
  logic                    write_any;
  logic                    short_conv;

  // A short frame still converts when the convert bit is held
  assign short_conv = !mode_sync[1] && frame_rise && !word_seen
                    && ctrl[`ADCC_BIT_CONVERT];
  assign write_any  = par_take || ser_write;

  always_comb begin
    next_ctrl      = ctrl;
    next_word_seen = word_seen;
    if (par_take) begin
      next_ctrl = data_s2;
    end else if (ser_write) begin
      next_ctrl = ser_word;
    end
    // Set wins over the clear at the start of a frame
    if (ser_write) begin
      next_word_seen = 1'b1;
    end else if (frame_fall) begin
      next_word_seen = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl      <= `ADCC_CTRL_RESET;
      word_seen <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      word_seen <= next_word_seen;
    end
  end

  // ==========================================================
  // Acquisition pulse and conversion sequence
  logic      timer_start;
  logic      timer_active;
  logic      timer_expire;
  adcc_seq_t seq;
  adcc_seq_t next_seq;
  logic      next_convert_start;

  // Every write carries an address, so every write restarts the pulse
  assign timer_start = write_any || short_conv;

  adcc_pulse_timer #(
    .CYCLES (ACQ_CYCLES)
  ) u_timer (
    .mclk   (mclk),
    .sys_rst(sys_rst),
    .start  (timer_start),
    .active (timer_active),
    .expire (timer_expire)
  );

  always_comb begin
    next_seq           = seq;
    next_convert_start = 1'b0;
    unique case (seq)
      ADCC_SEQ_IDLE: begin
        if (timer_start) begin
          next_seq = ADCC_SEQ_ACQ;
        end else if (hw_rise && !ctrl[`ADCC_BIT_CONVERT]) begin
          next_convert_start = 1'b1;
        end
      end
      ADCC_SEQ_ACQ: begin
        if (timer_expire && !timer_start) begin
          next_seq = ctrl[`ADCC_BIT_CONVERT] ? ADCC_SEQ_START
                                             : ADCC_SEQ_IDLE;
        end
      end
      ADCC_SEQ_START: begin
        next_seq           = timer_start ? ADCC_SEQ_ACQ : ADCC_SEQ_IDLE;
        next_convert_start = 1'b1;
      end
      default: begin
        next_seq = ADCC_SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      seq           <= ADCC_SEQ_IDLE;
      convert_start <= 1'b0;
    end else begin
      seq           <= next_seq;
      convert_start <= next_convert_start;
    end
  end

  // ==========================================================
  // Outputs
  logic [RES_W-1:0] next_result;
  logic             next_result_valid;

  always_comb begin
    next_result       = result_out;
    next_result_valid = raw_result_valid;
    if (raw_result_valid) begin
      // Straight binary in; flipping the top bit gives twos complement
      next_result = ctrl[`ADCC_BIT_CODING]
                  ? {~raw_result[RES_W-1], raw_result[RES_W-2:0]}
                  : raw_result;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      chan_select   <= 3'h0;
      chan_number   <= 4'h1;
      standby       <= 1'b0;
      twos_comp_sel <= 1'b0;
      acq_pulse     <= 1'b0;
      result_out    <= '0;
      result_valid  <= 1'b0;
    end else begin
      chan_select   <= ctrl[`ADCC_BIT_CHAN_HI:`ADCC_BIT_CHAN_LO];
      chan_number   <= {1'b0, ctrl[`ADCC_BIT_CHAN_HI:`ADCC_BIT_CHAN_LO]}
                     + 4'h1;
      standby       <= ctrl[`ADCC_BIT_STANDBY];
      twos_comp_sel <= ctrl[`ADCC_BIT_CODING];
      acq_pulse     <= timer_active;
      result_out    <= next_result;
      result_valid  <= next_result_valid;
    end
  end

  // ==========================================================
  // Checks
  AST_RESET_CLEAR: assert property (@(posedge mclk)
    sys_rst |=> ctrl == `ADCC_CTRL_RESET)
    else $error("control register not cleared by reset");

  AST_PAR_LATCH: assert property (@(posedge mclk) disable iff (sys_rst)
    par_take |=> ctrl == $past(data_s2))
    else $error("parallel write did not latch data lines");

  AST_SHORT_KEEP: assert property (@(posedge mclk) disable iff (sys_rst)
    (!write_any && !par_take) |=> ctrl == $past(ctrl))
    else $error("register changed without a complete write");

  AST_SHORT_CONV: assert property (@(posedge mclk) disable iff (sys_rst)
    short_conv |=> timer_active)
    else $error("short frame with convert set gave no pulse");

  AST_PULSE_LEN: assert property (@(posedge mclk) disable iff (sys_rst)
    (timer_start ##1 !timer_start [*2]) |-> timer_active)
    else $error("acquisition pulse ended early");

  AST_CONV_AFTER: assert property (@(posedge mclk) disable iff (sys_rst)
    convert_start |-> !$past(timer_active))
    else $error("conversion began during acquisition pulse");

  AST_CONV_BIT: assert property (@(posedge mclk) disable iff (sys_rst)
    (seq == ADCC_SEQ_ACQ && timer_expire && !timer_start
     && ctrl[`ADCC_BIT_CONVERT]) |=> ##1 convert_start)
    else $error("convert bit did not start a conversion");

  AST_CHAN_NUM: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 chan_number == {1'b0, $past(ctrl[5:3])} + 4'h1)
    else $error("channel number wrong");

  AST_CODING: assert property (@(posedge mclk) disable iff (sys_rst)
    (raw_result_valid && ctrl[`ADCC_BIT_CODING]) |=>
      result_out[RES_W-1] != $past(raw_result[RES_W-1]))
    else $error("twos complement coding not applied");

  AST_STANDBY: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 standby == $past(ctrl[`ADCC_BIT_STANDBY]))
    else $error("standby output does not follow its bit");
endmodule

// ==== adcc_cfg.svh ====
// Constants of the converter control register block
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH
`define ADCC_CTRL_W       6
`define ADCC_BIT_CODING   0
`define ADCC_BIT_STANDBY  1
`define ADCC_BIT_CONVERT  2
`define ADCC_BIT_CHAN_LO  3
`define ADCC_BIT_CHAN_HI  5
`define ADCC_CTRL_RESET   6'h00
`define ADCC_CLK_PERIOD_NS 10
`define ADCC_ACQ_TIME_NS  600
`define ADCC_ACQ_CYCLES \
  ((`ADCC_ACQ_TIME_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)
`define ADCC_SER_BITS     6
`define ADCC_RESULT_W     12
`endif

// ==== adcc_pkg.sv ====
// Types shared by the converter control register block
package adcc_pkg;
  typedef enum logic [1:0] {
    ADCC_SEQ_IDLE  = 2'b00,
    ADCC_SEQ_ACQ   = 2'b01,
    ADCC_SEQ_START = 2'b10
  } adcc_seq_t;
endpackage

// ==== adcc_serial_rx.sv ====
// Serial write receiver, runs on the host's serial clock
`timescale 1ns/1ns
`include "adcc_cfg.svh"
module adcc_serial_rx
  import adcc_pkg::*;
#(
  parameter int BITS = `ADCC_SER_BITS
) (
  input  wire logic            sclk,
  input  wire logic            write_frame_sync_n,
  input  wire logic            serial_data_in,
  output logic [BITS-1:0]      word,
  output logic                 word_full
);
  initial begin
    if (BITS < 2 || BITS > 15) $error("adcc_serial_rx: BITS out of range");
  end

  logic [3:0]      count;
  logic [3:0]      next_count;
  logic            next_full;
  logic [BITS-1:0] next_word;

  // ==========================================================
  // Capture
  always_comb begin
    next_count = count;
    next_full  = word_full;
    next_word  = word;
    if (count < 4'(BITS)) begin
      next_word  = {word[BITS-2:0], serial_data_in};
      next_count = count + 4'h1;
      next_full  = (count == 4'(BITS - 1));
    end
  end

  // The frame's own edge clears the count: sclk may stop between frames
  always_ff @(negedge sclk or posedge write_frame_sync_n) begin
    if (write_frame_sync_n) begin
      count     <= 4'h0;
      word_full <= 1'b0;
    end else begin
      count     <= next_count;
      word_full <= next_full;
    end
  end

  // Word is held past the frame end so the system side can copy it
  always_ff @(negedge sclk) begin
    if (!write_frame_sync_n) begin
      word <= next_word;
    end
  end
endmodule

// ==== adcc_pulse_timer.sv ====
// Acquisition pulse timer, restartable
`timescale 1ns/1ns
`include "adcc_cfg.svh"
module adcc_pulse_timer
  import adcc_pkg::*;
#(
  parameter int CYCLES = `ADCC_ACQ_CYCLES
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic start,
  output logic      active,
  output logic      expire
);
  initial begin
    if (CYCLES < 1 || CYCLES > 65535) $error("adcc_pulse_timer: bad CYCLES");
  end

  logic [15:0] count;
  logic [15:0] next_count;
  logic        next_active;
  logic        next_expire;

  // ==========================================================
  // Count down
  always_comb begin
    next_count  = count;
    next_active = active;
    next_expire = 1'b0;
    if (start) begin
      next_count  = 16'(CYCLES - 1);
      next_active = 1'b1;
    end else if (active) begin
      if (count == 16'h0000) begin
        next_active = 1'b0;
        next_expire = 1'b1;
      end else begin
        next_count = count - 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count  <= 16'h0000;
      active <= 1'b0;
      expire <= 1'b0;
    end else begin
      count  <= next_count;
      active <= next_active;
      expire <= next_expire;
    end
  end
endmodule

// ==== adcc_host_model.sv ====
// Host side model: framed serial writes on the host's own serial clock
`timescale 1ns/1ns
module adcc_host_model (
  output logic sclk,
  output logic write_frame_sync_n,
  output logic serial_data_in
);
  // Serial clock stands high outside frames
  initial begin
    sclk = 1'b1;
    write_frame_sync_n = 1'b0;
    serial_data_in = 1'b0;
    // Receiver clears only on a frame edge, so give it one at start
    #1 write_frame_sync_n = 1'b1;
  end
  // Sends n bits msb first; fewer than six aborts the frame.
  // Bits past the sixth are the inverted word, so a receiver
  // that wrongly kept them would show a different value.
  task automatic send(input logic [5:0] w, input int n);
    #33 write_frame_sync_n = 1'b0;
    for (int k = 0; k < n; k++) begin
      serial_data_in = (k < 6) ? w[5 - (k % 6)] : ~w[5 - (k % 6)];
      #62 sclk = 1'b0;
      #63 sclk = 1'b1;
    end
    #63 write_frame_sync_n = 1'b1;
    // Released data line shows the inverse of its last value
    serial_data_in = ~serial_data_in;
  endtask
endmodule

// ==== adcc_control_tb.sv ====
// Self-checking testbench of the converter control register
`timescale 1ns/1ns
`include "adcc_cfg.svh"
module adcc_control_tb;
  import adcc_pkg::*;
  // Short pulse keeps the run brief; the pulse length check expects ACQ cycles
  localparam int ACQ = 3;
  logic                    mclk;
  logic                    sys_rst;
  logic                    serial_mode;
  logic                    wr_n;
  logic                    cs_n;
  logic [`ADCC_CTRL_W-1:0] data_line;
  logic                    sclk;
  logic                    write_frame_sync_n;
  logic                    serial_data_in;
  logic                    hw_convert_start_n;
  logic [11:0]             raw_result;
  logic                    raw_result_valid;
  logic [2:0]              chan_select;
  logic [3:0]              chan_number;
  logic                    standby;
  logic                    twos_comp_sel;
  logic                    acq_pulse;
  logic                    convert_start;
  logic [11:0]             result_out;
  logic                    result_valid;
  int                      err_total = 0;
  int                      cmp_count = 0;
  int                      n_acq;
  int                      n_conv;

  adcc_control #(.ACQ_CYCLES(ACQ), .RES_W(12)) adcc_control_i (
    .mclk(mclk), .sys_rst(sys_rst), .serial_mode(serial_mode),
    .wr_n(wr_n), .cs_n(cs_n), .data_line(data_line), .sclk(sclk),
    .write_frame_sync_n(write_frame_sync_n),
    .serial_data_in(serial_data_in),
    .hw_convert_start_n(hw_convert_start_n), .raw_result(raw_result),
    .raw_result_valid(raw_result_valid), .chan_select(chan_select),
    .chan_number(chan_number), .standby(standby),
    .twos_comp_sel(twos_comp_sel), .acq_pulse(acq_pulse),
    .convert_start(convert_start), .result_out(result_out),
    .result_valid(result_valid)
  );

  adcc_host_model adcc_host_model_i (
    .sclk(sclk), .write_frame_sync_n(write_frame_sync_n),
    .serial_data_in(serial_data_in)
  );

  // ==========================================================
  // Tasks
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [11:0] got,
                       input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Counts pulse and conversion cycles over a window
  task automatic watch(input int n);
    n_acq = 0;
    n_conv = 0;
    repeat (n) begin
      cyc(1);
      n_acq += (acq_pulse === 1'b1);
      n_conv += (convert_start === 1'b1);
    end
  endtask

  task automatic pwrite(input logic [5:0] d, input logic cs);
    data_line = d;
    cs_n = cs;
    wr_n = 1'b0;
    cyc(4);
    wr_n = 1'b1;
    watch(30);
    cs_n = 1'b1;
  endtask

  // Watch runs alongside the frame and past its end: the take and any
  // conversion, a short frame's after the frame ends, land inside it
  task automatic swrite(input logic [5:0] w, input int n);
    fork
      adcc_host_model_i.send(w, n);
      watch(150);
    join
  endtask

  task automatic hwstart;
    hw_convert_start_n = 1'b0;
    cyc(4);
    hw_convert_start_n = 1'b1;
    watch(10);
  endtask

  task automatic res(input logic [11:0] r, input logic [11:0] e);
    raw_result = r;
    raw_result_valid = 1'b1;
    cyc(1);
    raw_result_valid = 1'b0;
    check("result_out", result_out, e);
    check("result_valid", result_valid, 12'h001);
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    sys_rst = 1'b1;
    serial_mode = 1'b1;
    wr_n = 1'b1;
    cs_n = 1'b1;
    data_line = 6'h00;
    hw_convert_start_n = 1'b1;
    raw_result = 12'h000;
    raw_result_valid = 1'b0;
    cyc(20);
    check("chan_select", chan_select, 12'h000);
    check("chan_number", chan_number, 12'h001);
    check("standby", standby, 12'h000);
    check("twos_comp_sel", twos_comp_sel, 12'h000);
    sys_rst = 1'b0;
    cyc(3);
    for (int c = 0; c < 8; c++) begin
      pwrite({c[2:0], 1'b0, c[0], c[1]}, 1'b0);
      check("chan_select", chan_select, c);
      check("chan_number", chan_number, c + 1);
      check("standby", standby, c[0]);
      check("twos_comp_sel", twos_comp_sel, c[1]);
      check("acq_seen", n_acq > 0, 12'h001);
      check("acq_len", n_acq, ACQ);
      check("conv_count", n_conv, 12'h000);
    end
    hwstart();
    check("conv_count", n_conv, 12'h001);
    pwrite(6'h00, 1'b1);
    check("chan_select", chan_select, 12'h007);
    res(12'h823, 12'h023);
    pwrite(6'h14, 1'b0);
    check("conv_count", n_conv, 12'h001);
    check("chan_select", chan_select, 12'h002);
    res(12'h823, 12'h823);
    hwstart();
    check("conv_count", n_conv, 12'h000);
    serial_mode = 1'b0;
    cyc(4);
    pwrite(6'h3F, 1'b0);
    check("chan_select", chan_select, 12'h002);
    swrite(6'h2A, 8);
    check("chan_select", chan_select, 12'h005);
    check("standby", standby, 12'h001);
    check("twos_comp_sel", twos_comp_sel, 12'h000);
    swrite(6'h39, 4);
    check("chan_select", chan_select, 12'h005);
    check("conv_count", n_conv, 12'h000);
    swrite(6'h34, 6);
    check("conv_count", n_conv, 12'h001);
    check("chan_select", chan_select, 12'h006);
    swrite(6'h00, 3);
    check("conv_count", n_conv, 12'h001);
    check("chan_select", chan_select, 12'h006);
    end_of_test;
  end

  // Tests need about 10 us; six times that cuts a hang short
  initial begin
    #60000;
    err_total++;
    end_of_test;
  end
endmodule
